// [shared/ltg_defs.svh]
// register map, field positions, reset values and divider counts of the timers
// assumes a 32-bit AXI4-Lite byte address compared in full
`ifndef LTG_DEFS_SVH
`define LTG_DEFS_SVH

`define LTG_LIFE_LOAD_ADDR 32'hFFFF0300
`define LTG_LIFE_LOW_ADDR 32'hFFFF0304
`define LTG_LIFE_HIGH_ADDR 32'hFFFF0308
`define LTG_LIFE_CTRL_ADDR 32'hFFFF030C
`define LTG_LIFE_CLEAR_ADDR 32'hFFFF0310
`define LTG_LIFE_CAPT_ADDR 32'hFFFF0314
`define LTG_GEN_LOAD_ADDR 32'hFFFF0320
`define LTG_GEN_COUNT_ADDR 32'hFFFF0324
`define LTG_GEN_CTRL_ADDR 32'hFFFF0328
`define LTG_GEN_CLEAR_ADDR 32'hFFFF032C
`define LTG_GEN_CAPT_ADDR 32'hFFFF0330

`define LTG_CTRL_RESET 32'h00000000
`define LTG_LOAD_RESET 32'h00000000
`define LTG_LIFE_CTRL_MASK 32'h0003F7DF
`define LTG_GEN_CTRL_MASK 32'h0003FFFF

`define LTG_PRESC_LSB 0
`define LTG_WIDE_BIT 4
`define LTG_FMT_LSB 4
`define LTG_PERIODIC_BIT 6
`define LTG_ENABLE_BIT 7
`define LTG_UP_BIT 8
`define LTG_CLKSEL_LSB 9
`define LTG_EVNUM_LSB 12
`define LTG_CAPEN_BIT 17
`define LTG_EVENT_COUNT 18

`define LTG_PRESC_DIV16 4'h4
`define LTG_PRESC_DIV256 4'h8
`define LTG_PRESC_DIV32768 4'hF
`define LTG_LIMIT_DIV16 15'h000F
`define LTG_LIMIT_DIV256 15'h00FF
`define LTG_LIMIT_DIV32768 15'h7FFF

`define LTG_HMS_FRAC_MAX 7'h7F
`define LTG_HMS_SEC_MAX 6'h3B
`define LTG_HMS_HOUR_MAX_DAY 8'h17
`define LTG_HMS_HOUR_MAX_FULL 8'hFF

`define LTG_RESP_OKAY 2'h0
`define LTG_RESP_SLVERR 2'h2

`endif

// [shared/ltg_pkg.sv]
// types shared by the timer block
// enum encodings are given here; other numeric constants come from ltg_defs.svh
package ltg_pkg;
	typedef enum logic [2:0] {
		LTG_SRC_NONE = 3'h0,
		LTG_SRC_OSC = 3'h1,
		LTG_SRC_XTAL = 3'h2,
		LTG_SRC_PERIPH = 3'h3,
		LTG_SRC_PIN = 3'h4,
		LTG_SRC_CORE = 3'h5
	} ltg_src_t;

	typedef enum logic [1:0] {
		LTG_FMT_BINARY = 2'h0,
		LTG_FMT_RESERVED = 2'h1,
		LTG_FMT_HMS_DAY = 2'h2,
		LTG_FMT_HMS_FULL = 2'h3
	} ltg_fmt_t;
endpackage

// [logic/ltg_tick_gen.sv]
// source selection, pin synchronisers and prescaler for one timer
// assumes slow clocks and the pin are asynchronous to ref_clk
`timescale 1ns/1ps
`include "ltg_defs.svh"
module ltg_tick_gen (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic slowOsc,
	input wire logic slowXtal,
	input wire logic peripheralClock,
	input wire logic clockPin,
	input wire ltg_pkg::ltg_src_t srcSel,
	input wire logic [3:0] prescale,
	input wire logic run,
	output logic tick
);
	import ltg_pkg::*;

	logic [3:0] rawClk;
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] sync3_reg;
	logic [3:0] rise;
	logic srcTick;
	logic [14:0] limit;
	logic [14:0] div_reg;

	assign rawClk = {clockPin, peripheralClock, slowXtal, slowOsc};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gSync
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
					sync3_reg[g] <= 1'b0;
				end else begin
					sync1_reg[g] <= rawClk[g];
					sync2_reg[g] <= sync1_reg[g];
					sync3_reg[g] <= sync2_reg[g];
				end
			end
			assign rise[g] = sync2_reg[g] & ~sync3_reg[g];
		end
	endgenerate

	// slow sources need no core gating
	always_comb begin
		case (srcSel)
			LTG_SRC_OSC: srcTick = rise[0];
			LTG_SRC_XTAL: srcTick = rise[1];
			LTG_SRC_PERIPH: srcTick = rise[2];
			LTG_SRC_PIN: srcTick = rise[3];
			LTG_SRC_CORE: srcTick = 1'b1;
			default: srcTick = 1'b0;
		endcase
	end

	assign limit = (prescale == `LTG_PRESC_DIV16) ? `LTG_LIMIT_DIV16 :
		(prescale == `LTG_PRESC_DIV256) ? `LTG_LIMIT_DIV256 :
		(prescale == `LTG_PRESC_DIV32768) ? `LTG_LIMIT_DIV32768 : 15'h0000;

	always_ff @(posedge ref_clk) begin
		if (srst || !run) begin
			div_reg <= 15'h0000;
			tick <= 1'b0;
		end else begin
			tick <= srcTick && (div_reg >= limit);
			if (srcTick) begin
				div_reg <= (div_reg >= limit) ? 15'h0000 : div_reg + 15'h0001;
			end
		end
	end
endmodule

// [logic/ltg_timers.sv]
// lifetime and general-purpose timers behind an AXI4-Lite slave
// assumes irqSources come from logic on ref_clk; clock sources are pins
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ltg_defs.svh"
module ltg_timers (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic slowOsc,
	input wire logic slowXtal,
	input wire logic peripheralClock,
	input wire logic clockPin,
	input wire logic [17:0] irqSources,
	output logic lifetimeIrq,
	output logic generalIrq
);
	import ltg_pkg::*;

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] hmsStep(input logic [31:0] v, input logic up,
		input logic [7:0] hourMax);
		logic [6:0] fr;
		logic [5:0] se;
		logic [5:0] mi;
		logic [7:0] hr;
		logic carry;
		fr = v[6:0];
		se = v[13:8];
		mi = v[21:16];
		hr = v[31:24];
		if (up) begin
			carry = (fr == `LTG_HMS_FRAC_MAX);
			fr = carry ? 7'h00 : fr + 7'h01;
			if (carry) begin
				carry = (se == `LTG_HMS_SEC_MAX);
				se = carry ? 6'h00 : se + 6'h01;
			end
			if (carry) begin
				carry = (mi == `LTG_HMS_SEC_MAX);
				mi = carry ? 6'h00 : mi + 6'h01;
			end
			if (carry) begin
				hr = (hr >= hourMax) ? 8'h00 : hr + 8'h01;
			end
		end else begin
			carry = (fr == 7'h00);
			fr = carry ? `LTG_HMS_FRAC_MAX : fr - 7'h01;
			if (carry) begin
				carry = (se == 6'h00);
				se = carry ? `LTG_HMS_SEC_MAX : se - 6'h01;
			end
			if (carry) begin
				carry = (mi == 6'h00);
				mi = carry ? `LTG_HMS_SEC_MAX : mi - 6'h01;
			end
			if (carry) begin
				hr = (hr == 8'h00) ? hourMax : hr - 8'h01;
			end
		end
		return {hr, 2'h0, mi, 2'h0, se, 1'h0, fr};
	endfunction

	logic [31:0] lifeCtrl_reg;
	logic [15:0] lifeLoad_reg;
	logic [47:0] lifeCount_reg;
	logic [31:0] lifeHighSnap_reg;
	logic [15:0] lifeCapt_reg;
	logic [31:0] genCtrl_reg;
	logic [31:0] genLoad_reg;
	logic [31:0] genCount_reg;
	logic [31:0] genCapt_reg;
	logic [17:0] srcPrev_reg;
	logic awHave_reg;
	logic wHave_reg;
	logic [31:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;

	wire lifeWide = lifeCtrl_reg[`LTG_WIDE_BIT];
	wire lifeRun = lifeCtrl_reg[`LTG_ENABLE_BIT];
	wire lifePeriodic = lifeCtrl_reg[`LTG_PERIODIC_BIT];
	wire lifeUp = lifeCtrl_reg[`LTG_UP_BIT] | lifeWide;
	wire [1:0] lifeClkSel = lifeCtrl_reg[`LTG_CLKSEL_LSB +: 2];
	wire genRun = genCtrl_reg[`LTG_ENABLE_BIT];
	wire genPeriodic = genCtrl_reg[`LTG_PERIODIC_BIT];
	wire genUp = genCtrl_reg[`LTG_UP_BIT];
	wire [2:0] genClkSel = genCtrl_reg[`LTG_CLKSEL_LSB +: 3];
	wire [1:0] genFmtBits = genCtrl_reg[`LTG_FMT_LSB +: 2];

	ltg_src_t lifeSrc;
	ltg_src_t genSrc;
	ltg_fmt_t genFmt;
	logic lifeTick;
	logic genTick;

	always_comb begin
		case (lifeClkSel)
			2'h0: lifeSrc = LTG_SRC_OSC;
			2'h1: lifeSrc = LTG_SRC_PERIPH;
			2'h2: lifeSrc = LTG_SRC_XTAL;
			default: lifeSrc = LTG_SRC_CORE;
		endcase
	end

	always_comb begin
		case (genClkSel)
			3'h0: genSrc = LTG_SRC_OSC;
			3'h1: genSrc = LTG_SRC_CORE;
			3'h2: genSrc = LTG_SRC_PERIPH;
			3'h3: genSrc = LTG_SRC_PIN;
			default: genSrc = LTG_SRC_NONE;
		endcase
	end

	assign genFmt = ltg_fmt_t'(genFmtBits);

	ltg_tick_gen uLifeTick (
		.ref_clk(ref_clk),
		.srst(srst),
		.slowOsc(slowOsc),
		.slowXtal(slowXtal),
		.peripheralClock(peripheralClock),
		.clockPin(clockPin),
		.srcSel(lifeSrc),
		.prescale(lifeCtrl_reg[`LTG_PRESC_LSB +: 4]),
		.run(lifeRun),
		.tick(lifeTick)
	);

	ltg_tick_gen uGenTick (
		.ref_clk(ref_clk),
		.srst(srst),
		.slowOsc(slowOsc),
		.slowXtal(slowXtal),
		.peripheralClock(peripheralClock),
		.clockPin(clockPin),
		.srcSel(genSrc),
		.prescale(genCtrl_reg[`LTG_PRESC_LSB +: 4]),
		.run(genRun),
		.tick(genTick)
	);

	// bus handshake decode
	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire arTake = s_axi_arvalid & s_axi_arready;
	wire doWrite = awHave_reg & wHave_reg & ~s_axi_bvalid;
	wire awHaveNext = (awHave_reg | awTake) & ~doWrite;
	wire wHaveNext = (wHave_reg | wTake) & ~doWrite;
	wire bvalidNext = doWrite | (s_axi_bvalid & ~s_axi_bready);
	wire rvalidNext = arTake | (s_axi_rvalid & ~s_axi_rready);

	wire wrLifeLoad = doWrite && awAddr_reg == `LTG_LIFE_LOAD_ADDR;
	wire wrLifeCtrl = doWrite && awAddr_reg == `LTG_LIFE_CTRL_ADDR;
	wire wrLifeClear = doWrite && awAddr_reg == `LTG_LIFE_CLEAR_ADDR;
	wire wrGenLoad = doWrite && awAddr_reg == `LTG_GEN_LOAD_ADDR;
	wire wrGenCtrl = doWrite && awAddr_reg == `LTG_GEN_CTRL_ADDR;
	wire wrGenClear = doWrite && awAddr_reg == `LTG_GEN_CLEAR_ADDR;
	// value addresses accept and ignore writes
	wire wrKnown = (awAddr_reg == `LTG_LIFE_LOW_ADDR) || (awAddr_reg == `LTG_LIFE_HIGH_ADDR) ||
		(awAddr_reg == `LTG_LIFE_CAPT_ADDR) || (awAddr_reg == `LTG_GEN_COUNT_ADDR) ||
		(awAddr_reg == `LTG_GEN_CAPT_ADDR) || wrLifeLoad || wrLifeCtrl || wrLifeClear ||
		wrGenLoad || wrGenCtrl || wrGenClear;

	// high word frozen by the low read
	wire rdLifeLow = arTake && s_axi_araddr == `LTG_LIFE_LOW_ADDR;
	logic [31:0] rdData;
	logic rdKnown;
	always_comb begin
		rdKnown = 1'b1;
		case (s_axi_araddr)
			`LTG_LIFE_LOAD_ADDR: rdData = {16'h0000, lifeLoad_reg};
			`LTG_LIFE_LOW_ADDR: rdData = {16'h0000, lifeCount_reg[15:0]};
			`LTG_LIFE_HIGH_ADDR: rdData = lifeHighSnap_reg;
			`LTG_LIFE_CTRL_ADDR: rdData = lifeCtrl_reg;
			`LTG_LIFE_CAPT_ADDR: rdData = {16'h0000, lifeCapt_reg};
			`LTG_GEN_LOAD_ADDR: rdData = genLoad_reg;
			`LTG_GEN_COUNT_ADDR: rdData = genCount_reg;
			`LTG_GEN_CTRL_ADDR: rdData = genCtrl_reg;
			`LTG_GEN_CAPT_ADDR: rdData = genCapt_reg;
			`LTG_LIFE_CLEAR_ADDR, `LTG_GEN_CLEAR_ADDR: rdData = 32'h00000000;
			default: begin
				rdData = 32'h00000000;
				rdKnown = 1'b0;
			end
		endcase
	end

	// event source pick, first assertion only
	wire [17:0] srcRise = irqSources & ~srcPrev_reg;
	wire [4:0] lifeEvNum = lifeCtrl_reg[`LTG_EVNUM_LSB +: 5];
	wire [4:0] genEvNum = genCtrl_reg[`LTG_EVNUM_LSB +: 5];
	wire lifeEvent = lifeCtrl_reg[`LTG_CAPEN_BIT] &&
		(lifeEvNum < 5'(`LTG_EVENT_COUNT)) && srcRise[lifeEvNum];
	wire genEvent = genCtrl_reg[`LTG_CAPEN_BIT] &&
		(genEvNum < 5'(`LTG_EVENT_COUNT)) && srcRise[genEvNum];

	wire [15:0] life16 = lifeCount_reg[15:0];
	wire lifeAtTerm = lifeWide ? (lifeCount_reg == 48'hFFFFFFFFFFFF) :
		(lifeUp ? (life16 == 16'hFFFF) : (life16 == 16'h0000));
	wire [7:0] hourMax = (genFmt == LTG_FMT_HMS_DAY) ? `LTG_HMS_HOUR_MAX_DAY :
		`LTG_HMS_HOUR_MAX_FULL;
	// binary unless a time format is chosen
	wire genHms = (genFmt == LTG_FMT_HMS_DAY) || (genFmt == LTG_FMT_HMS_FULL);
	wire [31:0] genMax = genHms ?
		{hourMax, 2'h0, 6'(`LTG_HMS_SEC_MAX), 2'h0, 6'(`LTG_HMS_SEC_MAX), 1'h0,
		7'(`LTG_HMS_FRAC_MAX)} : 32'hFFFFFFFF;
	wire genAtTerm = genUp ? (genCount_reg == genMax) : (genCount_reg == 32'h00000000);
	wire [31:0] genStepped = genHms ? hmsStep(genCount_reg, genUp, hourMax) :
		(genUp ? genCount_reg + 32'h00000001 : genCount_reg - 32'h00000001);

	// bus slave
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			awHave_reg <= 1'b0;
			wHave_reg <= 1'b0;
			awAddr_reg <= 32'h00000000;
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LTG_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `LTG_RESP_OKAY;
		end else begin
			awHave_reg <= awHaveNext;
			wHave_reg <= wHaveNext;
			if (awTake) begin
				awAddr_reg <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			s_axi_awready <= ~awHaveNext & ~bvalidNext;
			s_axi_wready <= ~wHaveNext & ~bvalidNext;
			s_axi_bvalid <= bvalidNext;
			if (doWrite) begin
				s_axi_bresp <= wrKnown ? `LTG_RESP_OKAY : `LTG_RESP_SLVERR;
			end
			s_axi_arready <= ~rvalidNext;
			s_axi_rvalid <= rvalidNext;
			if (arTake) begin
				s_axi_rdata <= rdData;
				s_axi_rresp <= rdKnown ? `LTG_RESP_OKAY : `LTG_RESP_SLVERR;
			end
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lifeCtrl_reg <= `LTG_CTRL_RESET;
			genCtrl_reg <= `LTG_CTRL_RESET;
			lifeLoad_reg <= 16'(`LTG_LOAD_RESET);
			genLoad_reg <= `LTG_LOAD_RESET;
			srcPrev_reg <= 18'h00000;
		end else begin
			srcPrev_reg <= irqSources;
			if (wrLifeCtrl) begin
				lifeCtrl_reg <= mergeBytes(lifeCtrl_reg, wData_reg, wStrb_reg) &
					`LTG_LIFE_CTRL_MASK;
			end
			if (wrGenCtrl) begin
				genCtrl_reg <= mergeBytes(genCtrl_reg, wData_reg, wStrb_reg) &
					`LTG_GEN_CTRL_MASK;
			end
			if (wrLifeLoad) begin
				lifeLoad_reg <= 16'(mergeBytes({16'h0000, lifeLoad_reg}, wData_reg, wStrb_reg));
			end
			if (wrGenLoad) begin
				genLoad_reg <= mergeBytes(genLoad_reg, wData_reg, wStrb_reg);
			end
		end
	end

	// lifetime counter
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lifeCount_reg <= 48'h000000000000;
			lifeHighSnap_reg <= 32'h00000000;
			lifeCapt_reg <= 16'h0000;
			lifetimeIrq <= 1'b0;
		end else begin
			if (rdLifeLow) begin
				lifeHighSnap_reg <= lifeCount_reg[47:16];
			end
			if (lifeEvent && !lifeWide) begin
				lifeCapt_reg <= life16;
			end
			if (wrLifeClear) begin
				lifeCount_reg <= lifeWide ? 48'h000000000000 : {32'h00000000, lifeLoad_reg};
			end else if (lifeTick) begin
				if (lifeAtTerm) begin
					if (lifeWide) begin
						lifeCount_reg <= 48'h000000000000;
					end else if (lifePeriodic) begin
						lifeCount_reg <= {32'h00000000, lifeLoad_reg};
					end else begin
						lifeCount_reg <= {32'h00000000, lifeUp ? 16'h0000 : 16'hFFFF};
					end
				end else if (lifeWide) begin
					lifeCount_reg <= lifeCount_reg + 48'h000000000001;
				end else begin
					lifeCount_reg <= {32'h00000000, lifeUp ? life16 + 16'h0001 :
						life16 - 16'h0001};
				end
			end
			// raise on terminal; clear wins over set
			// clear only acts in 16-bit mode
			if (lifeTick && lifeAtTerm && !wrLifeClear) begin
				lifetimeIrq <= 1'b1;
			end else if (wrLifeClear && !lifeWide) begin
				lifetimeIrq <= 1'b0;
			end
		end
	end

	// general counter
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			genCount_reg <= 32'h00000000;
			genCapt_reg <= 32'h00000000;
			generalIrq <= 1'b0;
		end else begin
			if (genEvent) begin
				genCapt_reg <= genCount_reg;
			end
			// reload on clear write, or on terminal when periodic
			if (wrGenClear) begin
				genCount_reg <= genLoad_reg;
			end else if (genTick) begin
				if (genAtTerm) begin
					genCount_reg <= genPeriodic ? genLoad_reg :
						(genUp ? 32'h00000000 : genMax);
				end else begin
					genCount_reg <= genStepped;
				end
			end
			if (genTick && genAtTerm && !wrGenClear) begin
				generalIrq <= 1'b1;
			end else if (wrGenClear) begin
				generalIrq <= 1'b0;
			end
		end
	end
endmodule

// [verification/ltg_timers_monitor.sv]
// bus and interrupt assertions for the timer block
// assumes it is bound to ltg_timers and sees only its ports
`timescale 1ns/1ps
`include "ltg_defs.svh"
module ltg_timers_monitor (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic lifetimeIrq,
	input wire logic generalIrq
);
	import ltg_pkg::*;
	logic [31:0] wrAddr;
	logic [31:0] rdAddr;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// addresses of the transfers in flight, for tying answers to causes
	always_ff @(posedge ref_clk) begin
		if (s_axi_awvalid && s_axi_awready)
			wrAddr <= s_axi_awaddr;
		if (s_axi_arvalid && s_axi_arready)
			rdAddr <= s_axi_araddr;
	end
	property p_reset_quiet;
		$fell(srst) |-> !lifetimeIrq && !generalIrq && !s_axi_bvalid;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("output active after reset");
	property p_gen_clear;
		$rose(s_axi_bvalid) && wrAddr == `LTG_GEN_CLEAR_ADDR |-> !generalIrq;
	endproperty
	a_gen_clear: assert property (p_gen_clear)
		else $error("general irq kept after clear write");
	property p_gen_sticky;
		$fell(generalIrq) |-> $past(srst) || ($rose(s_axi_bvalid) && wrAddr == `LTG_GEN_CLEAR_ADDR);
	endproperty
	a_gen_sticky: assert property (p_gen_sticky)
		else $error("general irq dropped without clear");
	property p_life_sticky;
		$fell(lifetimeIrq) |-> $past(srst) || ($rose(s_axi_bvalid) && wrAddr == `LTG_LIFE_CLEAR_ADDR);
	endproperty
	a_life_sticky: assert property (p_life_sticky)
		else $error("lifetime irq dropped without clear");
	property p_clear_reads;
		s_axi_rvalid && (rdAddr == `LTG_LIFE_CLEAR_ADDR || rdAddr == `LTG_GEN_CLEAR_ADDR)
			|-> s_axi_rdata == 32'h0 && s_axi_rresp == `LTG_RESP_OKAY;
	endproperty
	a_clear_reads: assert property (p_clear_reads)
		else $error("clear register read not zero");
	property p_value_wr_ok;
		$rose(s_axi_bvalid) && (wrAddr == `LTG_GEN_COUNT_ADDR || wrAddr == `LTG_LIFE_LOW_ADDR)
			|-> s_axi_bresp == `LTG_RESP_OKAY;
	endproperty
	a_value_wr_ok: assert property (p_value_wr_ok)
		else $error("value register write refused");
	property p_life_ctrl;
		s_axi_rvalid && rdAddr == `LTG_LIFE_CTRL_ADDR |-> (s_axi_rdata & ~`LTG_LIFE_CTRL_MASK) == 32'h0;
	endproperty
	a_life_ctrl: assert property (p_life_ctrl)
		else $error("lifetime control reserved bits set");
	property p_gen_ctrl;
		s_axi_rvalid && rdAddr == `LTG_GEN_CTRL_ADDR |-> (s_axi_rdata & ~`LTG_GEN_CTRL_MASK) == 32'h0;
	endproperty
	a_gen_ctrl: assert property (p_gen_ctrl)
		else $error("general control reserved bits set");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read not answered in time");
endmodule
bind ltg_timers ltg_timers_monitor ltg_timers_monitor_inst (.ref_clk, .srst, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .lifetimeIrq, .generalIrq);

// [verification/tb_top.sv]
// self-checking bench for the two timers over AXI4-Lite
// assumes the monitor is bound in by its own file; slow sources idle
`timescale 1ns/1ps
`include "ltg_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
	import ltg_pkg::*;
	logic ref_clk = 1'h0, srst = 1'h1;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [17:0] irqSources = 18'h0;
	logic slowOsc = 1'h0, slowXtal = 1'h0, peripheralClock = 1'h0, clockPin = 1'h0;
	logic lifetimeIrq, generalIrq;
	logic [31:0] rdat;
	logic [1:0] rsp;
	int bad_count = 0, n_tests = 0;
	always #25 ref_clk = ~ref_clk;
	ltg_timers ltg_timers_inst (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .slowOsc, .slowXtal, .peripheralClock, .clockPin,
		.irqSources, .lifetimeIrq, .generalIrq);
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic hang(input string what);
		bad_count++;
		$display("mismatch %s expected done seen timeout", what);
		print_verdict();
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		if (i == 50) hang("write");
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [31:0] a);
		int i;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		if (i == 50) hang("read");
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic pulse(input int k);
		irqSources[k] <= 1'h1;
		repeat (2) @(posedge ref_clk);
		irqSources[k] <= 1'h0;
	endtask
	task automatic t_reset();
		logic u;
		`CHK("irq", 2'h0, {lifetimeIrq, generalIrq})
		for (int a = 32'h300; a <= 32'h334; a += 4) begin
			rd(32'hFFFF0000 | 32'(a));
			u = a == 32'h318 || a == 32'h31C || a == 32'h334;
			`CHK("reset value", 32'h0, rdat)
			`CHK("read resp", u ? `LTG_RESP_SLVERR : `LTG_RESP_OKAY, rsp)
		end
		wr(32'hFFFF0318, 32'h1);
		`CHK("unmapped write", `LTG_RESP_SLVERR, rsp)
		$display("test reset done");
	endtask
	task automatic t_regs();
		logic [31:0] old;
		wr(`LTG_GEN_CTRL_ADDR, 32'hFFFFFFFF);
		rd(`LTG_GEN_CTRL_ADDR);
		`CHK("general control", `LTG_GEN_CTRL_MASK, rdat)
		wr(`LTG_LIFE_CTRL_ADDR, 32'hFFFFFFFF);
		rd(`LTG_LIFE_CTRL_ADDR);
		`CHK("lifetime control", `LTG_LIFE_CTRL_MASK, rdat)
		wr(`LTG_LIFE_LOAD_ADDR, 32'hFFFFFFFF);
		rd(`LTG_LIFE_LOAD_ADDR);
		`CHK("lifetime load", 32'h0000FFFF, rdat)
		wr(`LTG_GEN_LOAD_ADDR, 32'hA5A5A5A5);
		rd(`LTG_GEN_LOAD_ADDR);
		`CHK("general load", 32'hA5A5A5A5, rdat)
		wr(`LTG_GEN_CTRL_ADDR, 32'h0);
		wr(`LTG_LIFE_CTRL_ADDR, 32'h0);
		rd(`LTG_GEN_COUNT_ADDR);
		old = rdat;
		wr(`LTG_GEN_COUNT_ADDR, ~old);
		rd(`LTG_GEN_COUNT_ADDR);
		`CHK("count write", old, rdat)
		$display("test registers done");
	endtask
	task automatic t_prescale();
		logic [3:0] code [3] = '{4'h0, 4'h4, 4'h8};
		int dv [3] = '{1, 16, 256};
		logic [15:0] c0, d;
		for (int j = 0; j < 3; j++) begin
			// 16-bit, up, enabled, core clock
			wr(`LTG_LIFE_CTRL_ADDR, 32'h780 | 32'(code[j]));
			rd(`LTG_LIFE_LOW_ADDR);
			c0 = rdat[15:0];
			repeat (20 * dv[j]) @(posedge ref_clk);
			rd(`LTG_LIFE_LOW_ADDR);
			d = rdat[15:0] - c0;
			`CHK("prescale", 1'h1, d >= 20 && d <= 25)
		end
		wr(`LTG_LIFE_CTRL_ADDR, 32'h0);
		$display("test prescaler done");
	endtask
	task automatic t_irq(input logic [31:0] b, cv, ld, lo, hi);
		logic g;
		logic [31:0] ca, cl;
		int i;
		g = b[5];
		ca = b + (g ? 32'h8 : 32'hC);
		cl = b + (g ? 32'hC : 32'h10);
		wr(ca, 32'h0);
		wr(b, ld);
		wr(cl, 32'h0);
		rd(b + 32'h4);
		`CHK("reload", ld, rdat)
		wr(ca, cv);
		for (i = 0; i < 400 && (g ? generalIrq : lifetimeIrq) !== 1'h1; i++) @(posedge ref_clk);
		if (i == 400) hang("irq");
		rd(b + 32'h4);
		`CHK("restart", 1'h1, rdat >= lo && rdat <= hi)
		wr(cl, 32'h0);
		`CHK("irq clear", 1'h0, g ? generalIrq : lifetimeIrq)
		wr(ca, 32'h0);
		$display("test interrupt done");
	endtask
	task automatic t_hms();
		// 23 h time format, up, enabled, core clock; starts two ticks before the wrap
		wr(`LTG_GEN_LOAD_ADDR, 32'h173B3B7E);
		wr(`LTG_GEN_CLEAR_ADDR, 32'h0);
		wr(`LTG_GEN_CTRL_ADDR, 32'h3A0);
		repeat (8) @(posedge ref_clk);
		rd(`LTG_GEN_COUNT_ADDR);
		`CHK("time wrap", 1'h1, rdat <= 32'h0000000F)
		`CHK("time irq", 1'h1, generalIrq)
		wr(`LTG_GEN_CTRL_ADDR, 32'h0);
		wr(`LTG_GEN_CLEAR_ADDR, 32'h0);
		$display("test time format done");
	endtask
	task automatic t_capture(input logic [31:0] b, cv, input int n);
		logic g;
		logic [31:0] ca, pa, c0, cap;
		g = b[5];
		ca = b + (g ? 32'h8 : 32'hC);
		pa = b + (g ? 32'h10 : 32'h14);
		wr(b, 32'h0);
		wr(b + (g ? 32'hC : 32'h10), 32'h0);
		wr(ca, cv | 32'(n << 12));
		pulse(n ^ 1);
		rd(pa);
		`CHK("other event", 32'h0, rdat)
		rd(b + 32'h4);
		c0 = rdat;
		pulse(n);
		rd(pa);
		cap = rdat;
		rd(b + 32'h4);
		`CHK("capture", 1'h1, c0 < cap && cap < rdat)
		wr(ca, 32'h0);
		$display("test capture done");
	endtask
	task automatic t_wide();
		logic [31:0] lo;
		// 48-bit, enabled, core clock
		wr(`LTG_LIFE_CTRL_ADDR, 32'h690);
		wr(`LTG_LIFE_CLEAR_ADDR, 32'h0);
		repeat (65536) @(posedge ref_clk);
		rd(`LTG_LIFE_LOW_ADDR);
		lo = rdat;
		rd(`LTG_LIFE_HIGH_ADDR);
		`CHK("wide high", 32'h1, rdat)
		`CHK("wide low", 1'h1, lo < 32'h20)
		wr(`LTG_LIFE_CTRL_ADDR, 32'h0);
		$display("test wide done");
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'h0;
		@(posedge ref_clk);
		t_reset();
		t_regs();
		t_prescale();
		t_irq(32'hFFFF0320, 32'h3C0, 32'hFFFFFF00, 32'hFFFFFF00, 32'hFFFFFF20);
		t_irq(32'hFFFF0320, 32'h280, 32'h100, 32'hFFFFFF00, 32'hFFFFFFFF);
		t_irq(32'hFFFF0300, 32'h6C0, 32'h40, 32'h30, 32'h40);
		t_hms();
		t_capture(32'hFFFF0300, 32'h20780, 17);
		t_capture(32'hFFFF0320, 32'h20380, 0);
		t_wide();
		print_verdict();
	end
endmodule
